/* design/crash_dump_packet_builder.sv */
/*
 * Crash dump packet builder: takes the post-mortem command from the host
 * command byte stream and streams the crash dump status packet into the
 * status channel, with a CRC over the stack and one over the fixed body.
 * Assumes all inputs come from logic on ref_clk and hold still while a
 * dump runs; stack RAM answers a read one cycle after stack_rd.
 */
// Functional notes
// - accepted command puts all crash data into the status channel.
// - packet opens with status 0x0003, then two-byte count of following bytes.
// - bytes 0x04-0x83 carry the 32 saved core context words.
// - byte 0x84 is 1 after a crash, else 0.
// - byte 0x85 carries four validity and autoexec flags.
// - bytes 0x86-0x87 stack size, 0x88-0x8B stack start address.
// - bytes 0xA8-0xAC copy five host registers in order.
// - byte 0xAD codes reset cause 0,1,2,4.
// - byte 0xAF codes exception cause 0x19, 0x1B, 0x44.
// - bytes 0xB0-0xB7 protection fault cause then user stack pointer.
// - bytes 0xC4-0xC7 stack CRC; dump follows from byte 0xCC.
// - bytes 0xC8-0xCB CRC over bytes 0x04-0xC7.
// - diagnostic bits 8-10 give reset source, clear after power-on.
// - diagnostic bits 0-3 power state, bit 4 ROM write attempt.
`include "crash_dump_cfg.svh"

module crash_dump_packet_builder
	import crash_dump_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	// host command byte stream
	input  wire logic          cmd_valid,
	input  wire logic [7:0]    cmd_data,
	output logic               cmd_ready,
	output logic               cmd_reject,
	// status channel byte stream
	output logic               out_valid,
	output logic [7:0]         out_data,
	input  wire logic          out_ready,
	output logic               busy,
	// stack RAM read port
	output logic               stack_rd,
	output logic [31:0]        stack_addr,
	input  wire logic [7:0]    stack_rdata,
	// saved crash record
	input  wire logic [1023:0] context_regs,
	input  wire logic          crash_valid,
	input  wire logic          irq_ctrl_valid,
	input  wire logic          stack_info_valid,
	input  wire logic          stack_included,
	input  wire logic          no_autoexec,
	input  wire logic [15:0]   stack_size,
	input  wire logic [31:0]   stack_start,
	input  wire logic [159:0]  exception_regs,
	input  wire logic [3:0]    power_state_field,
	input  wire logic          rom_write_error,
	input  wire logic          rst_src_external,
	input  wire logic          rst_src_host,
	input  wire logic          rst_src_watchdog,
	input  wire logic [31:0]   interrupt_cause,
	input  wire logic [7:0]    debug_value,
	input  wire logic [7:0]    debug_state,
	input  wire logic [7:0]    error_value,
	input  wire logic [7:0]    error_aux,
	input  wire logic [7:0]    host_irq_ctrl,
	input  wire logic [7:0]    host_reset_count,
	input  wire exc_kind_t     exc_kind,
	input  wire logic [31:0]   protection_fault_cause,
	input  wire logic [31:0]   user_stack_pointer
);

	builder_t               st;
	builder_t               next_st;
	logic                   buf_ready;
	logic                   dump_on;
	logic [7:0]             flags;
	logic [31:0]            diag;
	logic [7:0]             reset_cause;
	logic [7:0]             exc_cause;
	logic [15:0]            length;
	logic [`FIXED_BYTES*8-1:0] image;

	// byte-serial reflected CRC-32 step
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h00_0000, d};
		for (int b = 0; b < 8; b++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// ****************************************************************
	// packet field assembly
	// ****************************************************************
	assign dump_on = stack_included && (stack_size != 16'h0000);
	assign length  = dump_on ? (`BASE_LENGTH + stack_size) : `BASE_LENGTH;

	// four flags in listed order, rest zero
	always_comb begin
		flags                    = 8'h00;
		flags[`FLAG_IRQ_CTRL_OK] = irq_ctrl_valid;
		flags[`FLAG_STACK_OK]    = stack_info_valid;
		flags[`FLAG_STACK_SENT]  = dump_on;
		flags[`FLAG_NO_AUTOEXEC] = no_autoexec;
	end

	// no source bit set means power-on, which leaves the field clear
	always_comb begin
		diag                                = 32'h0000_0000;
		diag[`DIAG_POWER_LSB +: 4]          = power_state_field;
		diag[`DIAG_ROM_ERR]                 = rom_write_error;
		diag[`DIAG_RST_SRC_LSB +: 3]        = {rst_src_watchdog, rst_src_host,
			rst_src_external};
	end

	// watchdog outranks host, host outranks external
	always_comb begin
		if (rst_src_watchdog) begin
			reset_cause = `RST_WATCHDOG;
		end else if (rst_src_host) begin
			reset_cause = `RST_HOST;
		end else if (rst_src_external) begin
			reset_cause = `RST_EXTERNAL;
		end else begin
			reset_cause = `RST_POWER_ON;
		end
	end

	always_comb begin
		case (exc_kind)
			EXK_WATCHDOG:  exc_cause = `EXC_WATCHDOG;
			EXK_FATAL:     exc_cause = `EXC_FATAL;
			EXK_UNHANDLED: exc_cause = `EXC_UNHANDLED;
			default:       exc_cause = `EXC_NONE;
		endcase
	end

	// fixed part of the packet, byte 0 in the low bits, fields little endian
	assign image = {
		st.crc ^ `CRC_INIT,
		st.stack_crc ^ `CRC_INIT,
		{`RESERVED_BITS{1'b0}},
		user_stack_pointer, protection_fault_cause,
		exc_cause, host_reset_count, reset_cause,
		host_irq_ctrl, error_aux, error_value,
		debug_state, debug_value,
		interrupt_cause, diag, exception_regs,
		stack_start, stack_size,
		flags,
		7'h00, crash_valid,
		context_regs,
		length, `STATUS_CRASH_DUMP
	};

	// ****************************************************************
	// command parse and packet sequencing
	// ****************************************************************
	always_comb begin
		next_st            = st;
		next_st.cmd_reject = 1'b0;
		next_st.stack_rd   = 1'b0;
		next_st.data_due   = st.stack_rd; // RAM data valid one cycle on
		if (st.push_valid && buf_ready) begin
			next_st.push_valid = 1'b0;
		end
		case (st.state)
			ST_IDLE: begin
				if (cmd_valid && st.cmd_ready) begin
					next_st.cmd     = {cmd_data, st.cmd[31:8]};
					next_st.hdr_cnt = st.hdr_cnt + 2'h1;
					if (st.hdr_cnt == 2'h3) begin
						next_st.cmd_ready = 1'b0;
						next_st.hdr_cnt   = 2'h0;
						if ({cmd_data, st.cmd[31:8]} ==
							{`CMD_ZERO_LENGTH, `CMD_POST_MORTEM}) begin
							next_st.busy      = 1'b1;
							next_st.crc       = `CRC_INIT;
							next_st.stack_crc = `CRC_INIT;
							next_st.idx       = 8'h00;
							next_st.cnt       = 16'h0000;
							next_st.state     = dump_on ? ST_PRECRC : ST_EMIT;
						end else begin
							next_st.state = ST_REJECT;
						end
					end
				end
			end
			ST_REJECT: begin
				// unknown or malformed header: flag it and rearm
				next_st.cmd_reject = 1'b1;
				next_st.cmd_ready  = 1'b1;
				next_st.state      = ST_IDLE;
			end
			ST_PRECRC: begin
				// stack CRC precedes the dump, so the stack is read twice
				if (st.data_due) begin
					next_st.stack_crc = crc_step(st.stack_crc, stack_rdata);
					next_st.cnt       = st.cnt + 16'h0001;
					if (st.cnt + 16'h0001 == stack_size) begin
						next_st.cnt   = 16'h0000;
						next_st.state = ST_EMIT;
					end
				end else if (!st.stack_rd) begin
					next_st.stack_rd   = 1'b1;
					next_st.stack_addr = stack_start + {16'h0000, st.cnt};
				end
			end
			ST_EMIT: begin
				if (!st.push_valid || buf_ready) begin
					next_st.push_valid = 1'b1;
					next_st.push_data  = image[st.idx*8 +: 8];
					if (st.idx >= `CRC_FIRST && st.idx <= `CRC_LAST) begin
						next_st.crc = crc_step(st.crc, image[st.idx*8 +: 8]);
					end
					next_st.idx = st.idx + 8'h01;
					if (st.idx == `LAST_FIXED) begin
						next_st.state = dump_on ? ST_DUMP : ST_IDLE;
						next_st.busy  = dump_on;
						next_st.cmd_ready = !dump_on;
					end
				end
			end
			ST_DUMP: begin
				// one byte in flight keeps the push slot free for the reply
				if (st.data_due) begin
					next_st.push_valid = 1'b1;
					next_st.push_data  = stack_rdata;
					next_st.cnt        = st.cnt + 16'h0001;
					if (st.cnt + 16'h0001 == stack_size) begin
						next_st.state     = ST_IDLE;
						next_st.busy      = 1'b0;
						next_st.cmd_ready = 1'b1;
					end
				end else if (!st.stack_rd && !st.push_valid) begin
					next_st.stack_rd   = 1'b1;
					next_st.stack_addr = stack_start + {16'h0000, st.cnt};
				end
			end
			default: begin
				next_st.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st           <= '0;
			st.state     <= ST_IDLE;
			st.cmd_ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// status channel buffer and outputs
	// ****************************************************************
	crash_dump_skid_buffer #(
		.WIDTH(8)
	) u_buffer (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.in_valid (st.push_valid),
		.in_data  (st.push_data),
		.in_ready (buf_ready),
		.out_valid(out_valid),
		.out_data (out_data),
		.out_ready(out_ready)
	);

	assign cmd_ready  = st.cmd_ready;
	assign cmd_reject = st.cmd_reject;
	assign busy       = st.busy;
	assign stack_rd   = st.stack_rd;
	assign stack_addr = st.stack_addr;

endmodule

/* common/crash_dump_cfg.svh */
/*
 * Constants of the crash dump packet builder: command and status codes,
 * packet offsets, field positions, encodings and the CRC set-up.
 * Assumes it is included by bare name; defines only.
 */
`ifndef CRASH_DUMP_CFG_SVH
`define CRASH_DUMP_CFG_SVH

// command header, little endian on the wire
`define CMD_POST_MORTEM   16'h0001
`define CMD_ZERO_LENGTH   16'h0000
`define STATUS_CRASH_DUMP 16'h0003

// packet layout
`define FIXED_BYTES       8'hCC
`define LAST_FIXED        8'hCB
`define CRC_FIRST         8'h04
`define CRC_LAST          8'hC7
`define BASE_LENGTH       16'h00C8
`define RESERVED_BITS     96

// flags byte bit positions
`define FLAG_IRQ_CTRL_OK  0
`define FLAG_STACK_OK     1
`define FLAG_STACK_SENT   2
`define FLAG_NO_AUTOEXEC  3

// diagnostic word field positions
`define DIAG_POWER_LSB    0
`define DIAG_ROM_ERR      4
`define DIAG_RST_SRC_LSB  8

// reset cause byte
`define RST_POWER_ON      8'h00
`define RST_EXTERNAL      8'h01
`define RST_HOST          8'h02
`define RST_WATCHDOG      8'h04

// exception cause byte
`define EXC_NONE          8'h00
`define EXC_WATCHDOG      8'h19
`define EXC_FATAL         8'h1B
`define EXC_UNHANDLED     8'h44

// reflected CRC-32
`define CRC_POLY          32'hEDB8_8320
`define CRC_INIT          32'hFFFF_FFFF

`endif

/* common/crash_dump_pkg.sv */
/*
 * Types shared by the crash dump packet builder and its testbench.
 * Assumes crash_dump_cfg.svh supplies the numeric constants.
 */
package crash_dump_pkg;

	// ****************************************************************
	// builder states, one-hot
	// ****************************************************************
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_REJECT = 5'h02,
		ST_PRECRC = 5'h04,
		ST_EMIT   = 5'h08,
		ST_DUMP   = 5'h10
	} dump_state_t;

	// kind of the exception behind the last crash
	typedef enum logic [1:0] {
		EXK_NONE      = 2'h0,
		EXK_WATCHDOG  = 2'h1,
		EXK_FATAL     = 2'h2,
		EXK_UNHANDLED = 2'h3
	} exc_kind_t;

	// ****************************************************************
	// builder state record
	// ****************************************************************
	typedef struct packed {
		dump_state_t state;
		logic [1:0]  hdr_cnt;
		logic [31:0] cmd;
		logic        cmd_ready;
		logic        cmd_reject;
		logic [7:0]  idx;
		logic [15:0] cnt;
		logic [31:0] crc;
		logic [31:0] stack_crc;
		logic        stack_rd;
		logic        data_due;
		logic [31:0] stack_addr;
		logic        push_valid;
		logic [7:0]  push_data;
		logic        busy;
	} builder_t;

endpackage

/* design/crash_dump_skid_buffer.sv */
/*
 * Two-entry buffer between the packet builder and the status channel.
 * Assumes one clock with a synchronous active-low reset; the head entry
 * is the output register, the second entry catches a word during a stall.
 */
module crash_dump_skid_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);

	typedef struct packed {
		logic             head_v;
		logic [WIDTH-1:0] head_d;
		logic             tail_v;
		logic [WIDTH-1:0] tail_d;
	} skid_t;

	skid_t st;
	skid_t next_st;
	logic  push;
	logic  pop;

	// ready depends on flops only, so no path from out_ready to in_ready
	assign in_ready  = !st.tail_v;
	assign out_valid = st.head_v;
	assign out_data  = st.head_d;
	assign push      = in_valid && !st.tail_v;
	assign pop       = st.head_v && out_ready;

	// ****************************************************************
	// entry movement
	// ****************************************************************
	always_comb begin
		next_st = st;
		if (pop) begin
			if (st.tail_v) begin
				next_st.head_d = st.tail_d;
				next_st.tail_v = 1'b0;
			end else if (push) begin
				next_st.head_d = in_data;
			end else begin
				next_st.head_v = 1'b0;
			end
		end else if (push) begin
			if (!st.head_v) begin
				next_st.head_v = 1'b1;
				next_st.head_d = in_data;
			end else begin
				next_st.tail_v = 1'b1; // stall: park the word
				next_st.tail_d = in_data;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

/* bench/crash_dump_properties.sv */
/*
 * Checker of the crash dump packet builder's port behaviour.
 * Assumes it is bound to the builder and shares its one clock and reset.
 */
module crash_dump_properties (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic       cmd_reject,
	input wire logic       out_valid,
	input wire logic [7:0] out_data,
	input wire logic       out_ready,
	input wire logic       busy,
	input wire logic       stack_rd
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// packet position
	// ****************
	logic [15:0] pos;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// count handed-over bytes, back to zero once the channel is idle;
	// the cycle after busy falls may still hold the last byte in flight
	always_ff @(posedge ref_clk) begin
		if (!rstn || (!busy && !$past(busy) && !out_valid))
			pos <= 16'h0000;
		else if (out_valid && out_ready)
			pos <= pos + 16'h0001;
	end

	sequence s_start;
		$rose(busy);
	endsequence
	sequence s_first_out;
		##[1:1000] out_valid;
	endsequence

	AST_BUSY_START: assert property (s_start |-> $past(cmd_valid && cmd_ready))
		else $error("dump started without a taken command byte");
	AST_FIRST_OUT: assert property (s_start |-> s_first_out)
		else $error("no status byte after dump start");
	AST_NO_CMD_BUSY: assert property (busy |-> !cmd_ready)
		else $error("command taken during dump");
	AST_REJ_PULSE: assert property (cmd_reject |=> !cmd_reject)
		else $error("reject longer than one cycle");
	AST_REJ_QUIET: assert property (cmd_reject |-> cmd_ready && !busy && !out_valid)
		else $error("reject with output activity");
	AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("status byte lost in stall");
	AST_RD_SPACE: assert property (stack_rd |=> !stack_rd [*2])
		else $error("stack reads too close");
	AST_RD_BUSY: assert property (stack_rd |-> busy)
		else $error("stack read outside dump");
	AST_STATUS_LO: assert property (out_valid && pos == 16'h0000 |-> out_data == 8'h03)
		else $error("status code low byte wrong");
	AST_STATUS_HI: assert property (out_valid && pos == 16'h0001 |-> out_data == 8'h00)
		else $error("status code high byte wrong");
	AST_VALID_BYTE: assert property (out_valid && pos == 16'h0084 |-> out_data[7:1] == 7'h00)
		else $error("valid byte not 0 or 1");
	AST_FLAGS_HI: assert property (out_valid && pos == 16'h0085 |-> out_data[7:4] == 4'h0)
		else $error("flag upper bits set");
	AST_RESERVED: assert property (out_valid && pos inside {[16'h00B8:16'h00C3]} |-> out_data == 8'h00)
		else $error("reserved byte not zero");
endmodule

bind crash_dump_packet_builder crash_dump_properties chk (.ref_clk(ref_clk), .rstn(rstn),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_reject(cmd_reject),
	.out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
	.busy(busy), .stack_rd(stack_rd));

/* bench/crash_dump_host_model.sv */
/*
 * Host model: sends command headers and collects status channel bytes.
 * Assumes the builder's outputs are registers on ref_clk.
 */
module crash_dump_host_model (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	output logic            cmd_valid,
	output logic [7:0]      cmd_data,
	input  wire logic       cmd_ready,
	input  wire logic       out_valid,
	input  wire logic [7:0] out_data,
	output logic            out_ready,
	input  wire logic       stall
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// host side
	// ****************
	logic [7:0] rx[$];
	logic [1:0] tick;

	initial begin
		cmd_valid = 1'b0;
		cmd_data = 8'hFF;
		out_ready = 1'b0;
		tick = 2'h0;
	end

	// id then length, lowest byte first; a byte stays until taken
	task send_cmd(input logic [31:0] hdr);
		int i;
		for (i = 0; i < 4; i++) begin
			cmd_valid = 1'b1;
			cmd_data = hdr[8*i+:8];
			while (cmd_ready !== 1'b1) begin
				@(posedge ref_clk);
				#1;
			end
			@(posedge ref_clk);
			#1;
		end
		cmd_valid = 1'b0;
		cmd_data = ~cmd_data; // released line shows no stale byte
		// let an edge pass so a following call never re-raises valid in this step
		@(posedge ref_clk);
		#1;
	endtask

	// stalled receiver takes one byte in four
	always @(posedge ref_clk) begin
		#1;
		tick <= tick + 2'h1;
		out_ready <= !stall || tick == 2'h0;
	end

	// sample at the falling edge, where the registered head is settled
	always @(negedge ref_clk) begin
		if (rstn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
			rx.push_back(out_data);
	end
endmodule

/* bench/crash_dump_packet_builder_test.sv */
/*
 * Testbench of the crash dump packet builder: builds the expected packet
 * from the crash inputs, sends commands through the host model and compares.
 * Assumes the stack RAM answers one cycle after a read strobe.
 */
module crash_dump_packet_builder_test import crash_dump_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// stimulus and checks
	// ****************
	logic          ref_clk, rstn, stall, inc, pend;
	logic          cmd_valid, cmd_ready, cmd_reject, out_valid, out_ready, busy, stack_rd;
	logic [7:0]    cmd_data, out_data, stack_rdata, s;
	logic [31:0]   stack_addr, ra, crc;
	logic [15:0]   size, n;
	logic [2:0]    rs;
	logic [1023:0] ctx;
	logic [159:0]  exr;
	exc_kind_t     k;
	logic [7:0]    p[0:255];
	logic [7:0]    exp_q[$];
	int            fail_count = 0, num_checks = 0, cyc = 0, rej = 0;

	crash_dump_packet_builder DUT (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .cmd_reject(cmd_reject),
		.out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .busy(busy),
		.stack_rd(stack_rd), .stack_addr(stack_addr), .stack_rdata(stack_rdata),
		.context_regs(ctx), .crash_valid(s[0]), .irq_ctrl_valid(s[1]),
		.stack_info_valid(s[2]), .stack_included(inc), .no_autoexec(s[3]),
		.stack_size(size), .stack_start({24'h000001, s}), .exception_regs(exr),
		.power_state_field(s[7:4]), .rom_write_error(s[5]), .rst_src_external(rs[0]),
		.rst_src_host(rs[1]), .rst_src_watchdog(rs[2]), .interrupt_cause({4{s}}),
		.debug_value(s ^ 8'h01), .debug_state(s ^ 8'h02), .error_value(s ^ 8'h03),
		.error_aux(s ^ 8'h04), .host_irq_ctrl(s ^ 8'h05), .host_reset_count(~s),
		.exc_kind(k), .protection_fault_cause({s, 24'hB0B1B2}),
		.user_stack_pointer({24'hB4B5B6, s}));

	crash_dump_host_model host (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .out_valid(out_valid),
		.out_data(out_data), .out_ready(out_ready), .stall(stall));

	function automatic logic [7:0] ram(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction

	// reflected crc-32, one byte at a time
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		int b;
		c = c ^ {24'h000000, d};
		for (b = 0; b < 8; b++)
			c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		return c;
	endfunction

	task put(input int at, input logic [63:0] v, input int nb);
		int j;
		for (j = 0; j < nb; j++)
			p[at + j] = v[8*j+:8];
	endtask

	// expected packet from the crash inputs, little endian fields
	task build();
		int j;
		n = (inc && size != 16'h0000) ? size : 16'h0000;
		for (j = 0; j < 256; j++)
			p[j] = 8'h00;
		put(0, {16'h00C8 + n, 16'h0003}, 4);
		for (j = 0; j < 128; j++)
			p[4 + j] = ctx[8*j+:8];
		p[132] = {7'h00, s[0]};
		p[133] = {4'h0, s[3], n != 16'h0000, s[2], s[1]};
		put(134, {24'h000001, s, size}, 6);
		for (j = 0; j < 20; j++)
			p[140 + j] = exr[8*j+:8];
		put(160, {21'h000000, rs, 3'h0, s[5], s[7:4]}, 4);
		put(164, {4{s}}, 4);
		for (j = 0; j < 5; j++)
			p[168 + j] = s ^ 8'(j + 1);
		p[173] = rs[2] ? 8'h04 : rs[1] ? 8'h02 : {7'h00, rs[0]};
		p[174] = ~s;
		p[175] = k == EXK_NONE ? 8'h00 : k == EXK_WATCHDOG ? 8'h19 : k == EXK_FATAL ? 8'h1B : 8'h44;
		put(176, {24'hB4B5B6, s, s, 24'hB0B1B2}, 8);
		crc = 32'hFFFFFFFF;
		for (j = 0; j < n; j++)
			crc = crc_step(crc, ram({24'h000001, s} + 32'(j)));
		put(196, ~crc, 4);
		crc = 32'hFFFFFFFF;
		for (j = 4; j < 200; j++)
			crc = crc_step(crc, p[j]);
		put(200, ~crc, 4);
		exp_q.delete();
		for (j = 0; j < 204; j++)
			exp_q.push_back(p[j]);
		for (j = 0; j < n; j++)
			exp_q.push_back(ram({24'h000001, s} + 32'(j)));
	endtask

	task check_byte(input logic [7:0] got, input logic [7:0] want);
		num_checks++;
		if (got !== want) begin
			fail_count++;
			$display("ERROR %0t byte %h expected %h", $time, got, want);
		end
	endtask

	task check_num(input int got, input int want);
		num_checks++;
		if (got != want) begin
			fail_count++;
			$display("ERROR %0t count %0d expected %0d", $time, got, want);
		end
	endtask

	task cmp(input int lo, input int hi);
		int j;
		for (j = lo; j < hi; j++)
			check_byte(host.rx[j], exp_q[j]);
	endtask

	task test_done();
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// stack ram: data only in the cycle after a read, a moving pattern otherwise
	always @(negedge ref_clk) begin
		if (stack_rd === 1'b1) begin
			pend = 1'b1;
			ra = stack_addr;
		end
	end
	always @(posedge ref_clk) begin
		#1;
		stack_rdata = pend ? ram(ra) : ~stack_rdata;
		pend = 1'b0;
	end

	always @(negedge ref_clk) begin
		if (cmd_reject === 1'b1)
			rej++;
	end

	// hang guard, well above four packets, two of them stalled
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			$display("ERROR %0t timeout", $time);
			test_done();
		end
	end

	initial begin
		int i, j;
		rstn = 1'b0;
		{stall, inc, pend, stack_rdata, s, size, rs, ctx, exr, ra} = '0;
		k = EXK_NONE;
		repeat (16) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		// every exception kind and reset cause, stalls on odd passes
		for (i = 0; i < 4; i++) begin
			s = 8'h20 + 8'(61 * i);
			size = 16'(i == 0 ? 0 : 6 - i);
			inc = i != 2;
			rs = 3'((1 << i) - 1);
			stall = i[0];
			k = exc_kind_t'(i);
			for (j = 0; j < 128; j++)
				ctx[8*j+:8] = s + 8'(j);
			for (j = 0; j < 20; j++)
				exr[8*j+:8] = s ^ 8'(j);
			build();
			host.rx.delete();
			host.send_cmd(32'h00000001);
			// look at busy off the edge that launches it
			while (host.rx.size() < exp_q.size() || busy !== 1'b0) begin
				@(posedge ref_clk);
				#1;
			end
			repeat (4) @(posedge ref_clk);
			#1;
			check_num(host.rx.size(), exp_q.size());
			cmp(0, 132);
			cmp(132, 176);
			cmp(176, exp_q.size());
		end
		// nonzero length, then a foreign id: both refused, nothing sent
		host.rx.delete();
		host.send_cmd(32'h00010001);
		host.send_cmd(32'h00000002);
		repeat (8) @(posedge ref_clk);
		#1;
		check_num(rej, 2);
		check_num(host.rx.size(), 0);
		test_done();
	end
endmodule
